// File: design/fault_mux_comparator_irq.sv
// Fault mux configuration, comparator seven threshold select and interrupt status.
// Assumes an AXI4-Lite master on clk_i, analog and pin inputs asynchronous,
// digital comparator, conduction and threshold-source inputs on clk_i.
//
// Function
// - Comparator seven keeps a 7-bit threshold code in bits 14 to 8, reset to zero.
// - A 3-bit source select picks the code, the ramp, or loop filter zero, one or two.
// - The comparator seven polarity bit picks below-threshold or above-threshold and resets to one.
// - The comparator seven interrupt enable, reset to zero, gates its interrupt flag.
// - Bit 0 routes the comparator seven DAC onto the analog pin when set, reset to zero.
// - Each fault pin has an edge polarity bit in bits 11 to 8, zero falling, one rising, reset to one.
// - Each fault pin has an interrupt enable in bits 7 to 4, reset to zero.
// - Each fault pin has a detection enable in bits 3 to 0; cleared, nothing is detected.
// - Reading the interrupt status register clears its flags.
// - Status layout is digital comparators 16..13, oscillator 12, pins 11..8, conduction 7, analog 6..0.
// - The oscillator bit reads one once a slow oscillator failure was seen.
// - The conduction bit reads zero when discontinuous conduction was detected.
// - A fault pin bit reads one once a detection event was found on that pin while its interrupt enable was set.
// - A comparator bit reads one while its threshold interrupt is pending.
// - A raw status register of the same layout shows live conditions and is not cleared by reads.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module fault_mux_comparator_irq
    import fault_mux_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [31:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [31:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [5:0]  acmp_result_i,
    input  wire logic        cmp7_above_i,
    input  wire logic [3:0]  dcmp_result_i,
    input  wire logic        slow_osc_fail_i,
    input  wire logic        dcm_detected_i,
    input  wire logic [3:0]  fault_pin_i,
    input  wire logic [6:0]  ramp_i,
    input  wire logic [6:0]  filt0_i,
    input  wire logic [6:0]  filt1_i,
    input  wire logic [6:0]  filt2_i,
    output logic [6:0]       cmp7_dac_code_o,
    output logic             cmp7_polarity_o,
    output logic             cmp7_dac_pin_en_o,
    output logic             irq_o
);

    if ($bits(stat_t) != STAT_W) begin : g_chk
        $error("Status layout width mismatch");
    end

    // Synchroniser and edge history
    async_t meta_q;
    async_t sync_q;
    async_t prev_q;
    async_t async_in;

    logic [3:0]  dcmp_prev_q;
    logic        dcm_prev_q;
    logic        cmp7_prev_q;

    cmp7_ctrl_t  ctrl_q;
    cmp7_ctrl_t  ctrl_d;
    fault_ctrl_t fctl_q;
    fault_ctrl_t fctl_d;
    stat_t       flag_q;
    stat_t       flag_d;
    logic [STAT_W-1:0] irq_en_q;
    logic [STAT_W-1:0] irq_en_d;
    logic [6:0]  code_q;
    logic [6:0]  code_d;

    // Bus state
    logic        aw_held_q;
    logic [31:0] awaddr_q;
    logic        w_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign async_in = '{fault: fault_pin_i, osc: slow_osc_fail_i,
                        cmp7_above: cmp7_above_i, acmp: acmp_result_i};

    // First stage feeds only the second; edges are taken from the second onward
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Event detection
    wire        cmp7_res;
    wire [3:0]  flt_rise;
    wire [3:0]  flt_fall;
    wire [3:0]  flt_evt;
    stat_t      evt;
    stat_t      gate;
    stat_t      set;

    assign cmp7_res = ctrl_q.pol ? sync_q.cmp7_above : ~sync_q.cmp7_above;
    assign flt_rise = sync_q.fault & ~prev_q.fault;
    assign flt_fall = ~sync_q.fault & prev_q.fault;
    assign flt_evt  = fctl_q.det_en & ((fctl_q.pol & flt_rise) | (~fctl_q.pol & flt_fall));

    assign evt = '{dcmp:  dcmp_result_i & ~dcmp_prev_q,
                   osc:   sync_q.osc & ~prev_q.osc,
                   fault: flt_evt,
                   dcm:   dcm_detected_i & ~dcm_prev_q,
                   acmp:  {cmp7_res & ~cmp7_prev_q, sync_q.acmp & ~prev_q.acmp}};

    // Sources whose enables live elsewhere latch unconditionally
    assign gate = '{dcmp: 4'hf, osc: 1'b1, fault: fctl_q.irq_en,
                    dcm: 1'b1, acmp: {ctrl_q.irq_en, 6'h3f}};

    assign set = evt & gate;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dcmp_prev_q <= '0;
            dcm_prev_q  <= 1'b0;
            cmp7_prev_q <= 1'b0;
        end else begin
            dcmp_prev_q <= dcmp_result_i;
            dcm_prev_q  <= dcm_detected_i;
            cmp7_prev_q <= cmp7_res;
        end
    end

    // Write channel
    wire        aw_take;
    wire        w_take;
    wire        wr_fire;
    wire [31:0] wa;
    wire [31:0] wdat;
    wire [3:0]  wstb;
    wire [31:0] wmask;
    wire [31:0] wd;
    wire        wr_cmp;
    wire        wr_flt;
    wire        wr_en;
    wire        wr_clr;
    wire        wr_ro;
    wire        wr_ok;

    assign s_axi_awready_o = !aw_held_q && !bvalid_q;
    assign s_axi_wready_o  = !w_held_q && !bvalid_q;
    assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
    assign wr_fire = (aw_held_q || aw_take) && (w_held_q || w_take);

    assign wa    = aw_held_q ? awaddr_q : s_axi_awaddr_i;
    assign wdat  = w_held_q ? wdata_q : s_axi_wdata_i;
    assign wstb  = w_held_q ? wstrb_q : s_axi_wstrb_i;
    assign wmask = {{8{wstb[3]}}, {8{wstb[2]}}, {8{wstb[1]}}, {8{wstb[0]}}};
    assign wd    = wdat & wmask;

    assign wr_cmp = wr_fire && (wa == CMP7_CTRL_ADDR);
    assign wr_flt = wr_fire && (wa == FAULT_CTRL_ADDR);
    assign wr_en  = wr_fire && (wa == IRQ_EN_ADDR);
    assign wr_clr = wr_fire && (wa == IRQ_CLR_ADDR);
    assign wr_ro  = (wa == INT_STAT_ADDR) || (wa == RAW_STAT_ADDR);
    assign wr_ok  = wr_ro || (wa == CMP7_CTRL_ADDR) || (wa == FAULT_CTRL_ADDR) ||
                    (wa == IRQ_EN_ADDR) || (wa == IRQ_CLR_ADDR);

    // Reserved bits are forced to zero on write so they read back as zero
    assign ctrl_d = wr_cmp ? cmp7_ctrl_t'(((ctrl_q & ~wmask) | wd) & CMP7_FIELDS) : ctrl_q;
    assign fctl_d = wr_flt ? fault_ctrl_t'(((fctl_q & ~wmask) | wd) & FAULT_FIELDS) : fctl_q;
    assign irq_en_d = wr_en ? ((irq_en_q & ~wmask[STAT_W-1:0]) | wd[STAT_W-1:0]) : irq_en_q;

    // Read channel
    wire        ar_take;
    wire [31:0] ra;
    wire        ar_cmp;
    wire        ar_flt;
    wire        ar_int;
    wire        ar_raw;
    wire        ar_en;
    wire        ar_clr;
    wire        rd_ok;
    wire [31:0] rd_data;
    stat_t      raw;
    wire [STAT_W-1:0] int_view;

    assign s_axi_arready_o = !rvalid_q;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign ra      = s_axi_araddr_i;
    assign ar_cmp  = ra == CMP7_CTRL_ADDR;
    assign ar_flt  = ra == FAULT_CTRL_ADDR;
    assign ar_int  = ra == INT_STAT_ADDR;
    assign ar_raw  = ra == RAW_STAT_ADDR;
    assign ar_en   = ra == IRQ_EN_ADDR;
    assign ar_clr  = ra == IRQ_CLR_ADDR;
    assign rd_ok   = ar_cmp || ar_flt || ar_int || ar_raw || ar_en || ar_clr;

    assign raw = '{dcmp: dcmp_result_i, osc: sync_q.osc, fault: sync_q.fault,
                   dcm: ~dcm_detected_i, acmp: {cmp7_res, sync_q.acmp}};
    assign int_view = flag_q ^ DCM_INV;

    assign rd_data = ar_cmp ? ctrl_q :
                     ar_flt ? fctl_q :
                     ar_int ? {{STAT_PAD{1'b0}}, int_view} :
                     ar_raw ? {{STAT_PAD{1'b0}}, raw} :
                     ar_en  ? {{STAT_PAD{1'b0}}, irq_en_q} : '0;

    // Status flags: a new event in the clearing cycle survives
    wire              rd_int;
    wire [STAT_W-1:0] clr;

    assign rd_int = ar_take && ar_int;
    assign clr    = (rd_int ? {STAT_W{1'b1}} : '0) | (wr_clr ? wd[STAT_W-1:0] : '0);
    assign flag_d = (flag_q & ~clr) | set;

    assign irq_o = |(flag_q & irq_en_q);

    // Threshold source select
    assign code_d = (ctrl_q.src == SRC_RAMP)  ? ramp_i :
                    (ctrl_q.src == SRC_FILT0) ? filt0_i :
                    (ctrl_q.src == SRC_FILT1) ? filt1_i :
                    (ctrl_q.src == SRC_FILT2) ? filt2_i : ctrl_q.code;

    assign cmp7_dac_code_o   = code_q;
    assign cmp7_polarity_o   = ctrl_q.pol;
    assign cmp7_dac_pin_en_o = ctrl_q.dac_en;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q   <= CMP7_CTRL_RST;
            fctl_q   <= FAULT_CTRL_RST;
            irq_en_q <= '0;
            flag_q   <= '0;
            code_q   <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            fctl_q   <= fctl_d;
            irq_en_q <= irq_en_d;
            flag_q   <= flag_d;
            code_q   <= code_d;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
            w_held_q  <= 1'b0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            aw_held_q <= !wr_fire && (aw_held_q || aw_take);
            w_held_q  <= !wr_fire && (w_held_q || w_take);
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr_i;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_data;
                rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o  = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o  = rdata_q;
    assign s_axi_rresp_o  = rresp_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_RD_CLEAR: assert property (
        (rd_int && (set == '0)) |=> (flag_q == '0))
        else $error("Status read did not clear flags");

    AST_SET_LATCH: assert property (
        (set != '0) |=> ((flag_q & $past(set)) == $past(set)))
        else $error("Event lost instead of latched");

    AST_IRQ_LEVEL: assert property (
        ((set & irq_en_q) != '0) && !wr_en |=> irq_o)
        else $error("Enabled flag did not raise interrupt");

    AST_FAULT_ONCE: assert property (
        (flt_evt != '0) |=> ((flt_evt & $past(flt_evt)) == '0))
        else $error("Fault edge gave two events");

    AST_DET_OFF: assert property (
        (fctl_q.det_en == '0) |-> (flt_evt == '0))
        else $error("Fault detected while detection disabled");

    AST_FAULT_RISE: assert property (
        ($rose(sync_q.fault[0]) && fctl_q.det_en[0] && fctl_q.pol[0]) |-> flt_evt[0])
        else $error("Rising fault edge missed");

    AST_CMP7_GATE: assert property (
        !ctrl_q.irq_en |-> !set.acmp[6])
        else $error("Comparator seven flagged while disabled");

    AST_SRC_CODE: assert property (
        (ctrl_q.src == SRC_CODE) |=> (code_q == $past(ctrl_q.code)))
        else $error("Threshold code not selected");

    AST_DCM_READ: assert property (
        (rd_int && flag_q.dcm) |=> ((rdata_q[STAT_W-1:0] & DCM_INV) == '0))
        else $error("Conduction bit sense wrong");

    AST_WR_RESP: assert property (
        wr_fire |=> (s_axi_bvalid_o && (s_axi_bresp_o == ($past(wr_ok) ? RESP_OKAY : RESP_SLVERR))))
        else $error("Write response missing");

    COV_RD_CLEAR: cover property (rd_int && (flag_q != '0));
    COV_FAULT:    cover property (set.fault != '0);
    COV_IRQ_DROP: cover property (irq_o ##1 !irq_o);

endmodule : fault_mux_comparator_irq

`default_nettype wire

// File: inc/fault_mux_pkg.sv
// Register map, field layouts, reset values and bus constants of the fault mux.
// Assumes a 32-bit AXI4-Lite slave port with byte addresses.
`default_nettype none

package fault_mux_pkg;

    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STAT_W   = 17;
    localparam int unsigned STAT_PAD = DATA_W - STAT_W;

    localparam logic [31:0] CMP7_CTRL_ADDR  = 32'h0013000c;
    localparam logic [31:0] FAULT_CTRL_ADDR = 32'h00130010;
    localparam logic [31:0] RAW_STAT_ADDR   = 32'h00130018;
    localparam logic [31:0] INT_STAT_ADDR   = 32'h00150014;
    localparam logic [31:0] IRQ_EN_ADDR     = 32'h00150018;
    localparam logic [31:0] IRQ_CLR_ADDR    = 32'h0015001c;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Threshold sources of comparator seven
    localparam logic [2:0] SRC_CODE  = 3'h0;
    localparam logic [2:0] SRC_RAMP  = 3'h1;
    localparam logic [2:0] SRC_FILT0 = 3'h2;
    localparam logic [2:0] SRC_FILT1 = 3'h3;
    localparam logic [2:0] SRC_FILT2 = 3'h4;

    typedef struct packed {
        logic [16:0] rsv_hi;
        logic [6:0]  code;
        logic [1:0]  rsv_lo;
        logic [2:0]  src;
        logic        pol;
        logic        irq_en;
        logic        dac_en;
    } cmp7_ctrl_t;

    typedef struct packed {
        logic [19:0] rsv;
        logic [3:0]  pol;
        logic [3:0]  irq_en;
        logic [3:0]  det_en;
    } fault_ctrl_t;

    typedef struct packed {
        logic [3:0] dcmp;
        logic       osc;
        logic [3:0] fault;
        logic       dcm;
        logic [6:0] acmp;
    } stat_t;

    // Inputs that arrive from outside the clock domain
    typedef struct packed {
        logic [3:0] fault;
        logic       osc;
        logic       cmp7_above;
        logic [5:0] acmp;
    } async_t;

    localparam cmp7_ctrl_t  CMP7_CTRL_RST   = cmp7_ctrl_t'(32'h00000004);
    localparam fault_ctrl_t FAULT_CTRL_RST  = fault_ctrl_t'(32'h00000f00);
    localparam logic [31:0] CMP7_FIELDS     = 32'h00007f3f;
    localparam logic [31:0] FAULT_FIELDS    = 32'h00000fff;
    localparam logic [16:0] DCM_INV         = 17'h00080;

endpackage : fault_mux_pkg

`default_nettype wire

// File: verification/fault_mux_comparator_irq_test.sv
// Self-checking bench for the fault mux: register map, comparator seven select and interrupt status.
// Assumes a single-clock AXI4-Lite slave that answers in its own time; assertions live in the design files.
`timescale 1ns/100ps
`default_nettype none

module fault_mux_comparator_irq_test;
    import fault_mux_pkg::*;

    logic        clk_i;
    logic        resetn_i;
    logic [31:0] awaddr, wdata, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  wstrb, dcmp, pins;
    logic [3:0]  wr_strb;
    logic [5:0]  acmp;
    logic        above, osc_fail, dcm;
    logic [6:0]  ramp, filt0, filt1, filt2;
    wire  logic  awready, wready, bvalid, arready, rvalid, pol_o, pin_en_o, irq;
    wire  logic [1:0]  bresp, rresp;
    wire  logic [31:0] rdata;
    wire  logic [6:0]  dac_code;
    int          n_fail;
    int          checks_done;
    logic [31:0] rd;
    logic [1:0]  rs;

    fault_mux_comparator_irq dut (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .acmp_result_i(acmp), .cmp7_above_i(above), .dcmp_result_i(dcmp), .slow_osc_fail_i(osc_fail),
        .dcm_detected_i(dcm), .fault_pin_i(pins), .ramp_i(ramp), .filt0_i(filt0), .filt1_i(filt1),
        .filt2_i(filt2), .cmp7_dac_code_o(dac_code), .cmp7_polarity_o(pol_o),
        .cmp7_dac_pin_en_o(pin_en_o), .irq_o(irq)
    );

    always #2 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Ready is looked at on the falling edge, so the handshake edge that follows is known without a race
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done, aw_now, w_now;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge clk_i);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= wr_strb;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk_i);
            aw_now = awready && !aw_done;
            w_now  = wready && !w_done;
            @(posedge clk_i);
            if (aw_now) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_now) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        @(negedge clk_i);
        while (!bvalid) @(negedge clk_i);
        r = bresp;
        @(posedge clk_i);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(negedge clk_i);
        while (!arready) @(negedge clk_i);
        @(posedge clk_i);
        arvalid <= 1'b0;
        @(negedge clk_i);
        while (!rvalid) @(negedge clk_i);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
        rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
    endtask : wr

    task automatic test_reset;
        axi_read(CMP7_CTRL_ADDR, rd, rs);
        check(rd, 32'h00000004);
        check(rs, RESP_OKAY);
        axi_read(FAULT_CTRL_ADDR, rd, rs);
        check(rd, 32'h00000f00);
        check({dac_code, pol_o, pin_en_o, irq}, {7'h00, 1'b1, 1'b0, 1'b0});
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000080);
        axi_read(32'h00130004, rd, rs);
        check(rd, 32'h00000000);
        check(rs, RESP_SLVERR);
        axi_write(32'h00130004, 32'hffffffff, rs);
        check(rs, RESP_SLVERR);
        wr(CMP7_CTRL_ADDR, 32'hffffffff);
        axi_read(CMP7_CTRL_ADDR, rd, rs);
        check(rd, CMP7_FIELDS);
        wr(CMP7_CTRL_ADDR, 32'h00000004);
        $display("test reset done");
    endtask : test_reset

    task automatic test_fault;
        wr(FAULT_CTRL_ADDR, 32'h00000d7b);
        wr(IRQ_EN_ADDR, 32'h00000300);
        @(posedge clk_i);
        pins <= 4'b1101;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        check(irq, 1'b1);
        wr(IRQ_EN_ADDR, 32'h00000000);
        @(negedge clk_i);
        check(irq, 1'b0);
        wr(IRQ_EN_ADDR, 32'h00000300);
        wr(IRQ_CLR_ADDR, 32'h00000100);
        @(negedge clk_i);
        check(irq, 1'b1);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000280);
        @(negedge clk_i);
        check(irq, 1'b0);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000080);
        @(posedge clk_i);
        pins <= 4'b0010;
        repeat (8) @(posedge clk_i);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000080);
        $display("test fault done");
    endtask : test_fault

    task automatic test_status;
        wr(CMP7_CTRL_ADDR, 32'h00000006);
        @(posedge clk_i);
        dcmp     <= 4'b1010;
        osc_fail <= 1'b1;
        dcm      <= 1'b1;
        acmp     <= 6'b100001;
        above    <= 1'b1;
        repeat (8) @(posedge clk_i);
        axi_read(RAW_STAT_ADDR, rd, rs);
        check(rd, 32'h00015261);
        axi_read(RAW_STAT_ADDR, rd, rs);
        check(rd, 32'h00015261);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00015061);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000080);
        wr(CMP7_CTRL_ADDR, 32'h00000002);
        repeat (6) @(posedge clk_i);
        axi_read(RAW_STAT_ADDR, rd, rs);
        check(rd[6], 1'b0);
        $display("test status done");
    endtask : test_status

    task automatic test_source;
        logic [6:0] exp_src [0:5];
        exp_src = '{7'h7f, 7'h11, 7'h22, 7'h33, 7'h44, 7'h7f};
        for (int s = 0; s < 6; s++) begin
            wr(CMP7_CTRL_ADDR, 32'h00007f01 | (s << 3));
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            check(dac_code, exp_src[s]);
        end
        check({pol_o, pin_en_o}, 2'b01);
        axi_read(CMP7_CTRL_ADDR, rd, rs);
        check(rd, 32'h00007f29);
        // Only byte lane one is written, so the low control bits must survive
        wr_strb = 4'h2;
        wr(CMP7_CTRL_ADDR, 32'h000005ff);
        wr_strb = 4'hf;
        axi_read(CMP7_CTRL_ADDR, rd, rs);
        check(rd, 32'h00000529);
        @(posedge clk_i);
        above <= 1'b0;
        repeat (6) @(posedge clk_i);
        axi_read(RAW_STAT_ADDR, rd, rs);
        check(rd, 32'h00015261);
        axi_read(INT_STAT_ADDR, rd, rs);
        check(rd, 32'h00000080);
        $display("test source done");
    endtask : test_source

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #20000;
        n_fail++;
        results();
    end

    initial begin
        clk_i = 1'b0;
        resetn_i = 1'b0;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h0;
        wr_strb = 4'hf;
        dcmp = 4'h0;
        pins = 4'b0010;
        acmp = 6'h00;
        {above, osc_fail, dcm} = 3'b000;
        ramp = 7'h11;
        filt0 = 7'h22;
        filt1 = 7'h33;
        filt2 = 7'h44;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        test_reset();
        test_fault();
        test_status();
        test_source();
        results();
    end

endmodule : fault_mux_comparator_irq_test

`default_nettype wire
